//--- shared/pts_pkg.sv
/*
 * Shared constants and types of the pulse train sequencer: register map,
 * control field positions, trigger modes, table entry layout, timing.
 * Assumes a 100 MHz core clock and 32-bit APB data.
 */
package pts_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] PTS_OFF_CTRL = 12'h000;
	localparam logic [11:0] PTS_OFF_STATUS = 12'h004;
	localparam logic [11:0] PTS_OFF_TBL_LEN = 12'h008;
	localparam logic [11:0] PTS_OFF_TBL_IDX = 12'h00C;
	localparam logic [11:0] PTS_OFF_TBL_ON = 12'h010;
	localparam logic [11:0] PTS_OFF_TBL_OFF = 12'h014;
	localparam logic [11:0] PTS_OFF_TBL_CNT = 12'h018;
	localparam int PTS_ADDR_W = 12;

	// ----------------------------------------
	// Control and status fields
	// ----------------------------------------
	localparam int PTS_CTRL_W = 6;
	localparam logic [PTS_CTRL_W-1:0] PTS_CTRL_RST = 6'h00;
	localparam int PTS_CB_EN = 0;
	localparam int PTS_CB_MODE_LO = 1;
	localparam int PTS_CB_GATE_INV = 3;
	localparam int PTS_CB_SYNC_VALID = 4;
	localparam int PTS_CB_SLOPE_NEG = 5;
	localparam int PTS_CB_SW_TRIG = 7;
	localparam int PTS_SB_RUN = 0;
	localparam int PTS_SB_PULSE = 1;
	localparam int PTS_SB_ERR = 2;
	localparam int PTS_SB_ROW_LO = 16;

	// ----------------------------------------
	// Trigger modes and sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		PTS_TRIG_AUTO = 2'h0,
		PTS_TRIG_SINGLE = 2'h1,
		PTS_TRIG_EXT_SINGLE = 2'h2,
		PTS_TRIG_EXT_GATED = 2'h3
	} pts_trig_t;

	typedef enum logic [3:0] {
		PTS_ST_IDLE = 4'h1,
		PTS_ST_LOAD = 4'h2,
		PTS_ST_ON = 4'h4,
		PTS_ST_OFF = 4'h8
	} pts_state_t;

	// ----------------------------------------
	// Table entry and timing
	// ----------------------------------------
	localparam int PTS_TIME_W = 16;
	typedef struct packed {
		logic [PTS_TIME_W-1:0] on_us;
		logic [PTS_TIME_W-1:0] off_us;
		logic [PTS_TIME_W-1:0] count;
	} pts_entry_t;

	localparam int PTS_DEPTH = 256;
	localparam int PTS_CLK_NS = 10;
	localparam int PTS_US_NS = 1000;
	localparam int PTS_CYC_PER_US = PTS_US_NS / PTS_CLK_NS;
	localparam int PTS_SETTLE_NS = 2000;
	localparam int PTS_SETTLE_CYC = (PTS_SETTLE_NS + PTS_CLK_NS - 1) / PTS_CLK_NS;
endpackage

//--- shared/pts_tbl_if.sv
/*
 * Table port between the sequencer and its entry store: one write port,
 * one combinational read port.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface pts_tbl_if import pts_pkg::*; #(
	parameter int IDXW = 8
);
	logic wr_en;
	logic [IDXW-1:0] wr_idx;
	pts_entry_t wr_entry;
	logic [IDXW-1:0] rd_idx;
	pts_entry_t rd_entry;

	modport ctl (output wr_en, output wr_idx, output wr_entry, output rd_idx, input rd_entry);
	modport mem (input wr_en, input wr_idx, input wr_entry, input rd_idx, output rd_entry);
endinterface

//--- rtl/pts_table.sv
/*
 * Pulse table store: DEPTH entries of on time, off time and repeat count
 * held in flip-flops, written one entry at a time.
 * Assumes the writer never addresses beyond DEPTH-1.
 */
`timescale 1ns/1ps
module pts_table import pts_pkg::*; #(
	parameter int DEPTH = PTS_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Table port
	pts_tbl_if.mem tbl
);
	typedef struct packed {
		pts_entry_t [DEPTH-1:0] mem;
	} pts_tbl_state_t;

	pts_tbl_state_t s_q;
	pts_tbl_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (tbl.wr_en) begin
			s_d.mem[tbl.wr_idx] = tbl.wr_entry;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tbl.rd_entry = s_q.mem[tbl.rd_idx];
endmodule

//--- rtl/pts_us_tick.sv
/*
 * Microsecond time base: a one-cycle tick every CYC_PER_US enabled cycles.
 * The count freezes while en is low and restarts from zero on clr.
 * Assumes en and clr are synchronous to core_clk.
 */
`timescale 1ns/1ps
module pts_us_tick import pts_pkg::*; #(
	parameter int CYC_PER_US = PTS_CYC_PER_US
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic en,
	input wire logic clr,
	// Tick
	output logic tick
);
	localparam int CW = $clog2(CYC_PER_US + 1);
	localparam logic [CW-1:0] LAST = CW'(CYC_PER_US - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
	} pts_tick_state_t;

	pts_tick_state_t s_q;
	pts_tick_state_t s_d;

	assign tick = en && (s_q.cnt == LAST);

	always_comb begin
		s_d = s_q;
		if (clr) begin
			s_d.cnt = '0;
		end else if (tick) begin
			s_d.cnt = '0;
		end else if (en) begin
			s_d.cnt = s_q.cnt + CW'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

//--- rtl/pts_top.sv
/*
 * Pulse train sequencer: plays a table of on/off time pairs with repeat
 * counts onto the pulse output, under auto, single, external single or
 * external gated triggering, with a sync output, behind an APB slave.
 * Assumes APB, trigger and gate inputs synchronous to core_clk.
 */
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
//
// Summary of operation
// - Gate polarity matters only in gated mode
// - Normal polarity: output only while gate high
// - Inverse polarity: output only while gate low
// - Validity sync: high settling, low when stable
// - Otherwise one sync pulse per sequence start
// - Train built from stored on/off entries
// - Output high for entry on time, microseconds
// - Then low for entry off time, microseconds
// - Repeat each pair count times, then advance
// - Zero count entry skipped, stays in table
// - Table length set by length register, not fixed
// - Auto mode runs continuously, no trigger
// - External single: one sequence per edge
`timescale 1ns/1ps
module pts_top import pts_pkg::*; #(
	parameter int DEPTH = PTS_DEPTH,
	parameter int CYC_PER_US = PTS_CYC_PER_US,
	parameter int SETTLE_CYC = PTS_SETTLE_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PTS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External trigger and gate
	input wire logic ext_trig,
	input wire logic ext_gate,
	// Outputs
	output logic pulse_out,
	output logic sync_out
);
	localparam int IDXW = $clog2(DEPTH);
	localparam logic [IDXW:0] DEPTH_L = (IDXW + 1)'(DEPTH);
	localparam int SW = $clog2(SETTLE_CYC + 1);
	localparam logic [SW-1:0] SETTLE_L = SW'(SETTLE_CYC);

	typedef struct packed {
		pts_state_t st;
		logic [IDXW-1:0] row;
		logic [PTS_TIME_W-1:0] rep;
		logic [PTS_TIME_W-1:0] tmr;
		logic [PTS_CTRL_W-1:0] ctrl;
		logic [IDXW:0] len;
		logic [IDXW-1:0] widx;
		logic [PTS_TIME_W-1:0] on_stage;
		logic [PTS_TIME_W-1:0] off_stage;
		logic err;
		logic trig_prev;
		logic gate;
		logic [SW-1:0] settle;
		logic pulse;
		logic sync;
		logic [31:0] rdata;
	} pts_top_state_t;

	pts_top_state_t s_q;
	pts_top_state_t s_d;

	pts_tbl_if #(.IDXW(IDXW)) tbl ();

	logic tick;
	logic tick_en;
	logic tick_clr;

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	// parameterised table depth
	pts_table #(.DEPTH(DEPTH)) u_table (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tbl(tbl.mem)
	);

	pts_us_tick #(.CYC_PER_US(CYC_PER_US)) u_tick (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.en(tick_en),
		.clr(tick_clr),
		.tick(tick)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic hit(input logic [PTS_ADDR_W-1:0] a, input logic [PTS_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	function automatic logic mapped(input logic [PTS_ADDR_W-1:0] a);
		mapped = hit(a, PTS_OFF_CTRL) || hit(a, PTS_OFF_STATUS) || hit(a, PTS_OFF_TBL_LEN)
			|| hit(a, PTS_OFF_TBL_IDX) || hit(a, PTS_OFF_TBL_ON) || hit(a, PTS_OFF_TBL_OFF)
			|| hit(a, PTS_OFF_TBL_CNT);
	endfunction

	logic acc;
	logic wr;
	logic setup_rd;
	logic sw_trig;
	pts_trig_t mode;
	logic enable;
	logic run;
	logic gate_ok;
	logic trig_edge;
	logic trig_evt;
	logic continuous;
	logic seq_start;
	logic last_row;
	pts_entry_t ent;

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped(paddr);
	assign prdata = s_q.rdata;
	assign pulse_out = s_q.pulse;
	assign sync_out = s_q.sync;

	assign mode = pts_trig_t'(s_q.ctrl[PTS_CB_MODE_LO +: 2]);
	assign enable = s_q.ctrl[PTS_CB_EN];
	assign sw_trig = wr && hit(paddr, PTS_OFF_CTRL) && pwdata[PTS_CB_SW_TRIG];
	assign run = enable && (s_q.len != '0);
	assign gate_ok = (mode != PTS_TRIG_EXT_GATED)
		|| (s_q.ctrl[PTS_CB_GATE_INV] ? !ext_gate : ext_gate);
	assign trig_edge = s_q.ctrl[PTS_CB_SLOPE_NEG] ? (s_q.trig_prev && !ext_trig)
		: (!s_q.trig_prev && ext_trig);
	assign trig_evt = ((mode == PTS_TRIG_EXT_SINGLE) && trig_edge)
		|| ((mode == PTS_TRIG_SINGLE) && sw_trig);
	assign continuous = (mode == PTS_TRIG_AUTO) || (mode == PTS_TRIG_EXT_GATED);
	assign last_row = ((IDXW + 1)'(s_q.row) + (IDXW + 1)'(1)) >= s_q.len;
	assign ent = tbl.rd_entry;

	assign tick_en = run && s_q.gate && ((s_q.st == PTS_ST_ON) || (s_q.st == PTS_ST_OFF));
	assign tick_clr = (s_d.st != s_q.st) || (s_d.tmr != s_q.tmr && !tick);

	assign tbl.rd_idx = s_q.row;
	assign tbl.wr_en = wr && hit(paddr, PTS_OFF_TBL_CNT);
	assign tbl.wr_idx = s_q.widx;
	assign tbl.wr_entry = '{on_us: s_q.on_stage, off_us: s_q.off_stage,
		count: pwdata[PTS_TIME_W-1:0]};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		seq_start = 1'b0;
		s_d.trig_prev = ext_trig;
		// Gate registered so phase timing lines up with the registered output
		s_d.gate = gate_ok;

		// Register writes
		if (wr && hit(paddr, PTS_OFF_CTRL)) begin
			s_d.ctrl = pwdata[PTS_CTRL_W-1:0];
			s_d.settle = SETTLE_L;
		end else if (s_q.settle != '0) begin
			s_d.settle = s_q.settle - SW'(1);
		end
		if (wr && hit(paddr, PTS_OFF_STATUS) && pwdata[PTS_SB_ERR]) begin
			s_d.err = 1'b0;
		end
		if (wr && hit(paddr, PTS_OFF_TBL_LEN)) begin
			s_d.len = ((IDXW + 1)'(pwdata[IDXW:0]) > DEPTH_L) ? DEPTH_L : pwdata[IDXW:0];
		end
		if (wr && hit(paddr, PTS_OFF_TBL_IDX)) begin
			s_d.widx = pwdata[IDXW-1:0];
		end
		if (wr && hit(paddr, PTS_OFF_TBL_ON)) begin
			s_d.on_stage = pwdata[PTS_TIME_W-1:0];
		end
		if (wr && hit(paddr, PTS_OFF_TBL_OFF)) begin
			s_d.off_stage = pwdata[PTS_TIME_W-1:0];
		end
		if (tbl.wr_en) begin
			s_d.widx = s_q.widx + IDXW'(1);
		end
		if (enable && (s_q.len == '0)) begin
			s_d.err = 1'b1;
		end

		// Sequencer
		if (!run) begin
			s_d.st = PTS_ST_IDLE;
			s_d.row = '0;
		end else begin
			unique case (s_q.st)
				PTS_ST_IDLE: begin
					if (continuous || trig_evt) begin
						s_d.row = '0;
						s_d.st = PTS_ST_LOAD;
						seq_start = 1'b1;
					end
				end
				PTS_ST_LOAD: begin
					if (ent.count == '0) begin
						if (last_row) begin
							s_d.row = '0;
							s_d.st = continuous ? PTS_ST_LOAD : PTS_ST_IDLE;
							seq_start = continuous;
						end else begin
							s_d.row = s_q.row + IDXW'(1);
						end
					end else begin
						s_d.rep = ent.count;
						s_d.tmr = ent.on_us;
						s_d.st = PTS_ST_ON;
					end
				end
				PTS_ST_ON: begin
					if (s_q.gate) begin
						if ((s_q.tmr == '0) || (tick && (s_q.tmr == PTS_TIME_W'(1)))) begin
							s_d.tmr = ent.off_us;
							s_d.st = PTS_ST_OFF;
						end else if (tick) begin
							s_d.tmr = s_q.tmr - PTS_TIME_W'(1);
						end
					end
				end
				PTS_ST_OFF: begin
					if (s_q.gate) begin
						if ((s_q.tmr == '0) || (tick && (s_q.tmr == PTS_TIME_W'(1)))) begin
							if (s_q.rep == PTS_TIME_W'(1)) begin
								s_d.st = PTS_ST_LOAD;
								if (last_row) begin
									s_d.row = '0;
									s_d.st = continuous ? PTS_ST_LOAD : PTS_ST_IDLE;
									seq_start = continuous;
								end else begin
									s_d.row = s_q.row + IDXW'(1);
								end
							end else begin
								s_d.rep = s_q.rep - PTS_TIME_W'(1);
								s_d.tmr = ent.on_us;
								s_d.st = PTS_ST_ON;
							end
						end else if (tick) begin
							s_d.tmr = s_q.tmr - PTS_TIME_W'(1);
						end
					end
				end
			endcase
		end

		s_d.pulse = run && gate_ok && (s_d.st == PTS_ST_ON);
		s_d.sync = s_q.ctrl[PTS_CB_SYNC_VALID] ? (s_d.settle != '0) : seq_start;

		// Read data captured in the setup phase
		s_d.rdata = '0;
		if (setup_rd) begin
			if (hit(paddr, PTS_OFF_CTRL)) begin
				s_d.rdata = 32'(s_q.ctrl);
			end else if (hit(paddr, PTS_OFF_STATUS)) begin
				s_d.rdata[PTS_SB_RUN] = (s_q.st != PTS_ST_IDLE);
				s_d.rdata[PTS_SB_PULSE] = s_q.pulse;
				s_d.rdata[PTS_SB_ERR] = s_q.err;
				s_d.rdata[PTS_SB_ROW_LO +: IDXW] = s_q.row;
			end else if (hit(paddr, PTS_OFF_TBL_LEN)) begin
				s_d.rdata = 32'(s_q.len);
			end else if (hit(paddr, PTS_OFF_TBL_IDX)) begin
				s_d.rdata = 32'(s_q.widx);
			end else if (hit(paddr, PTS_OFF_TBL_ON)) begin
				s_d.rdata = 32'(s_q.on_stage);
			end else if (hit(paddr, PTS_OFF_TBL_OFF)) begin
				s_d.rdata = 32'(s_q.off_stage);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: PTS_ST_IDLE, ctrl: PTS_CTRL_RST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end
endmodule

//--- verif/pts_monitor.sv
/* Port checker of the pulse sequencer.
   Assumes the bind below attaches it to pts_top. */
`timescale 1ns/1ps
module pts_monitor import pts_pkg::*; #(
	parameter int CYC_PER_US = PTS_CYC_PER_US,
	parameter int SETTLE_CYC = PTS_SETTLE_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PTS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Trigger, gate, outputs
	input wire logic ext_trig,
	input wire logic ext_gate,
	input wire logic pulse_out,
	input wire logic sync_out
);
	localparam int SETTLE_END = SETTLE_CYC + 3;
	typedef struct packed {
		logic [PTS_CTRL_W-1:0] ctrl;
		logic [15:0] hi_cnt;
	} pts_mon_t;
	pts_mon_t s_q;
	pts_mon_t s_d;
	logic acc;
	logic wr_ctrl;
	logic gated;
	logic ext_single;
	assign acc = psel && penable;
	assign wr_ctrl = acc && pready && pwrite && paddr == PTS_OFF_CTRL;
	assign gated = s_q.ctrl[2:1] == 2'h3;
	assign ext_single = s_q.ctrl[2:1] == 2'h2 && !s_q.ctrl[4] && !s_q.ctrl[5];
	// ----------------------------------------
	// Shadow of control and high-time count
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		if (wr_ctrl) s_d.ctrl = pwdata[PTS_CTRL_W-1:0];
		s_d.hi_cnt = pulse_out ? s_q.hi_cnt + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) s_q <= '0;
		else s_q <= s_d;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	unmapped_err_a: assert property (acc && paddr > 12'h018 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	idle_rdata_a: assert property (!acc |-> prdata == 32'h0)
		else $error("read data outside access");
	gate_norm_a: assert property ((gated && !s_q.ctrl[3] && !ext_gate)[*3] |-> !pulse_out)
		else $error("pulse while gate low");
	gate_inv_a: assert property ((gated && s_q.ctrl[3] && ext_gate)[*3] |-> !pulse_out)
		else $error("pulse while inverse gate high");
	sync_pulse_a: assert property ($rose(sync_out) && !s_q.ctrl[4] |=> !sync_out)
		else $error("sync pulse longer than one cycle");
	settle_high_a: assert property (wr_ctrl && pwdata[4] |-> ##2 sync_out)
		else $error("sync not high while settling");
	settle_low_a: assert property (wr_ctrl && pwdata[4] |-> ##SETTLE_END !sync_out)
		else $error("sync still high after settling");
	on_width_a: assert property ($fell(pulse_out) && !gated && s_q.ctrl[0]
		|-> s_q.hi_cnt % CYC_PER_US == 0)
		else $error("on time not whole microseconds");
	trig_sync_a: assert property ($rose(sync_out) && ext_single
		|-> $past(ext_trig) && !$past(ext_trig, 2))
		else $error("sync without trigger edge");
endmodule
bind pts_top pts_monitor #(.CYC_PER_US(CYC_PER_US), .SETTLE_CYC(SETTLE_CYC)) u_pts_monitor (
	.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_trig(ext_trig), .ext_gate(ext_gate), .pulse_out(pulse_out), .sync_out(sync_out));

//--- verif/pts_ext_src.sv
/* Trigger and gate source outside the sequencer.
   Assumes requests change just after core_clk edges. */
`timescale 1ns/1ps
module pts_ext_src (
	// Clock and pace
	input wire logic core_clk,
	input wire logic slow,
	// Requests
	input wire logic trig_req,
	input wire logic gate_req,
	// Lines
	output logic ext_trig,
	output logic ext_gate
);
	logic [1:0] t_q = 2'h0;
	logic [1:0] g_q = 2'h0;
	always_ff @(posedge core_clk) begin
		t_q <= {t_q[0], trig_req};
		g_q <= {g_q[0], gate_req};
	end
	// Slow pace adds one cycle of lag
	assign ext_trig = slow ? t_q[1] : t_q[0];
	assign ext_gate = slow ? g_q[1] : g_q[0];
endmodule

//--- verif/pts_top_tb.sv
/* Self-checking bench of the pulse sequencer.
   Assumes pts_top with bound checker and pts_ext_src. */
`timescale 1ns/1ps
module pts_top_tb import pts_pkg::*; ;
	localparam int CYC = 2;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, perr, ext_trig, ext_gate, pulse_out, sync_out;
	logic slow = 1'b0;
	logic trig_req = 1'b0;
	logic gate_req = 1'b0;
	int error_cnt = 0;
	int samples_checked = 0;
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	pts_top #(.DEPTH(8), .CYC_PER_US(CYC), .SETTLE_CYC(8)) u_pts_top (
		.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_trig(ext_trig), .ext_gate(ext_gate),
		.pulse_out(pulse_out), .sync_out(sync_out));
	pts_ext_src u_pts_ext_src (.core_clk(core_clk), .slow(slow), .trig_req(trig_req),
		.gate_req(gate_req), .ext_trig(ext_trig), .ext_gate(ext_gate));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
			error_cnt++;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) chk("pready", 1, 0);
		if (n == 20) print_verdict();
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic row(input logic [15:0] on, input logic [15:0] off, input logic [15:0] n);
		apb(1'b1, PTS_OFF_TBL_ON, {16'h0, on});
		apb(1'b1, PTS_OFF_TBL_OFF, {16'h0, off});
		apb(1'b1, PTS_OFF_TBL_CNT, {16'h0, n});
	endtask
	task automatic cnt(input int n, output int hi, output int sy);
		hi = 0;
		sy = 0;
		repeat (n) begin
			@(posedge core_clk);
			hi += int'(pulse_out === 1'b1);
			sy += int'(sync_out === 1'b1);
		end
	endtask
	task automatic meas(output int hi, output int lo);
		int n;
		hi = 0;
		lo = 0;
		for (n = 0; n < 500 && pulse_out !== 1'b1; n++) @(posedge core_clk);
		while (pulse_out === 1'b1 && hi < 500) begin
			@(posedge core_clk);
			hi++;
		end
		while (pulse_out === 1'b0 && lo < 500) begin
			@(posedge core_clk);
			lo++;
		end
		if (n == 500 || hi == 500 || lo == 500) chk("pulse wait", 1, 0);
		if (n == 500 || hi == 500 || lo == 500) print_verdict();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped err", 1, perr);
		apb(1'b1, PTS_OFF_CTRL, 32'h1);
		apb(1'b0, PTS_OFF_STATUS, 32'h0);
		chk("no list", 1, rd[PTS_SB_ERR]);
		apb(1'b1, PTS_OFF_CTRL, 32'h0);
		apb(1'b1, PTS_OFF_STATUS, 32'h4);
		apb(1'b0, PTS_OFF_STATUS, 32'h0);
		chk("err cleared", 0, rd[PTS_SB_ERR]);
		$display("test regs done");
	endtask
	task automatic t_train();
		int hi, lo, k;
		int exp_hi[5] = '{CYC, CYC, 2 * CYC, CYC, CYC};
		apb(1'b1, PTS_OFF_TBL_IDX, 32'h0);
		row(16'h1, 16'h2, 16'h2);
		row(16'h3, 16'h3, 16'h0);
		row(16'h2, 16'h1, 16'h1);
		apb(1'b1, PTS_OFF_TBL_LEN, 32'h3);
		apb(1'b1, PTS_OFF_CTRL, 32'h1);
		for (k = 0; k < 5; k++) begin
			meas(hi, lo);
			chk("on width", exp_hi[k], hi);
			if (k == 0) chk("off width", 2 * CYC, lo);
		end
		apb(1'b1, PTS_OFF_CTRL, 32'h0);
		$display("test train done");
	endtask
	task automatic t_gate();
		int c, s, hi;
		apb(1'b1, PTS_OFF_TBL_IDX, 32'h0);
		row(16'h5, 16'h14, 16'h1);
		apb(1'b1, PTS_OFF_TBL_LEN, 32'h1);
		apb(1'b1, PTS_OFF_CTRL, 32'h7);
		cnt(20, c, s);
		chk("gate low", 0, c);
		gate_req <= 1'b1;
		for (c = 0; c < 20 && pulse_out !== 1'b1; c++) @(posedge core_clk);
		cnt(2, hi, s);
		gate_req <= 1'b0;
		cnt(4, c, s);
		hi += c + 1;
		cnt(8, c, s);
		chk("gate off low", 0, c);
		gate_req <= 1'b1;
		cnt(20, c, s);
		chk("resumed on", 5 * CYC, hi + c);
		apb(1'b1, PTS_OFF_CTRL, 32'h0);
		apb(1'b1, PTS_OFF_CTRL, 32'hF);
		cnt(20, c, s);
		chk("inv gate high", 0, c);
		gate_req <= 1'b0;
		cnt(20, c, s);
		chk("inv gate low", 1, c > 0);
		apb(1'b1, PTS_OFF_CTRL, 32'h0);
		gate_req <= 1'b1;
		apb(1'b1, PTS_OFF_CTRL, 32'h9);
		cnt(20, c, s);
		chk("auto ignores gate", 1, c > 0);
		apb(1'b1, PTS_OFF_CTRL, 32'h0);
		$display("test gate done");
	endtask
	task automatic t_ext();
		int c, s;
		apb(1'b1, PTS_OFF_CTRL, 32'h5);
		cnt(20, c, s);
		chk("no edge", 0, c);
		trig_req <= 1'b1;
		cnt(80, c, s);
		chk("one sequence", 5 * CYC, c);
		chk("one sync", 1, s);
		trig_req <= 1'b0;
		cnt(60, c, s);
		chk("wrong edge", 0, c);
		slow <= 1'b1;
		trig_req <= 1'b1;
		cnt(80, c, s);
		chk("late edge", 5 * CYC, c);
		apb(1'b1, PTS_OFF_CTRL, 32'h3);
		cnt(20, c, s);
		chk("single no trigger", 0, c);
		apb(1'b1, PTS_OFF_CTRL, 32'h83);
		cnt(80, c, s);
		chk("soft single once", 5 * CYC, c);
		apb(1'b1, PTS_OFF_CTRL, 32'h10);
		@(posedge core_clk);
		chk("settling", 1, sync_out);
		repeat (20) @(posedge core_clk);
		chk("settled", 0, sync_out);
		$display("test ext and sync done");
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_train();
		t_gate();
		t_ext();
		print_verdict();
	end
endmodule
